//--- rtl/drs_pkg.sv
// Constants and types of the drive reset and diagnostic sequencer
`default_nettype none
package drs_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam longint CYC_PER_MS = longint'(CLK_MHZ) * 64'd1000;
	localparam longint T_DETECT_MS = 450;
	localparam longint T_SLAVE_MS = 5000;
	localparam longint T_PASSED_DIAG_LINE_N_MS = 6000;
	localparam longint T_IDLE_MS = 30000;
	localparam longint DETECT_CYC = T_DETECT_MS * CYC_PER_MS;
	localparam longint SLAVE_CYC = T_SLAVE_MS * CYC_PER_MS;
	localparam longint PASSED_DIAG_LINE_N_CYC = T_PASSED_DIAG_LINE_N_MS * CYC_PER_MS;
	localparam longint IDLE_CYC = T_IDLE_MS * CYC_PER_MS;
	localparam int CNT_W = 34;
	localparam logic [CNT_W-1:0] SYNC_SETTLE = 34'h0_0000_0002;
	// Register byte offsets and indices
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] OFS_TASK = 32'h0000_0008;
	localparam logic [31:0] OFS_HEAD = 32'h0000_000C;
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_TASK = 3'h2;
	localparam logic [2:0] IDX_HEAD = 3'h3;
	localparam logic [2:0] IDX_NONE = 3'h7;
	// Control register fields
	localparam int CTRL_SRST = 0;
	localparam int CTRL_DIAG = 1;
	localparam int CTRL_CMD = 2;
	localparam int CTRL_PASS = 3;
	localparam int CTRL_DONE = 4;
	localparam int CTRL_SPIN = 5;
	localparam int CTRL_CODE_LO = 8;
	localparam int CTRL_W = 16;
	// Status and error values
	localparam logic [7:0] ST_BUSY = 8'h80;
	localparam logic [7:0] ST_CLEAR = 8'h00;
	localparam logic [7:0] ST_READY = 8'h50;
	localparam logic [7:0] ERR_OK = 8'h01;
	localparam logic [7:0] ERR_SLV_FAIL = 8'h05;
	localparam logic [7:0] ERR_MISS_OK = 8'h09;
	localparam logic [7:0] ERR_MISS_FAIL = 8'h0B;
	localparam logic [7:0] ERR_DIAG_MISS_OK = 8'h81;
	localparam logic [7:0] ERR_DIAG_MISS_BASE = 8'h80;
	// Task-file values
	localparam logic [7:0] TF_SEC_INIT = 8'h01;
	localparam logic [7:0] TF_ZERO = 8'h00;
	// AHB
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	typedef enum logic [2:0] {
		ST_JUMP = 3'b000, ST_ANN = 3'b001, ST_DETECT = 3'b010, ST_RUN = 3'b011,
		ST_PWAIT = 3'b100, ST_SRST = 3'b101, ST_SPIN = 3'b110, ST_IDLE = 3'b111
	} drs_state_t;
	typedef enum logic [1:0] {FL_HARD = 2'b00, FL_SRST = 2'b01, FL_DIAG = 2'b10} drs_flow_t;
	typedef struct packed {
		drs_state_t state;
		drs_flow_t flow;
		logic [CNT_W-1:0] cnt;
		logic isMaster;
		logic slavePresent;
		logic postsBoth;
		logic [7:0] statusOwn;
		logic [7:0] statusPeer;
		logic [7:0] errReg;
		logic [7:0] secCount;
		logic [7:0] secNum;
		logic [7:0] cylLo;
		logic [7:0] cylHi;
		logic [7:0] drvHead;
		logic diagOut_n;
		logic diagOe;
		logic actOut_n;
		logic actOe;
		logic irq;
		logic idleDone;
		logic [1:0] jumpSync;
		logic [1:0] diagSync;
		logic [1:0] actSync;
		logic [CTRL_W-1:0] ctrl;
		logic wrPend;
		logic [2:0] wrIdx;
		logic [31:0] rdata;
	} drs_regs_t;
endpackage
`default_nettype wire

//--- rtl/drs_sequencer.sv
// Drive reset and diagnostic sequencer with AHB-Lite register access
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module drs_sequencer #(
	parameter logic [drs_pkg::CNT_W-1:0] DETECT_CYC = drs_pkg::CNT_W'(drs_pkg::DETECT_CYC),
	parameter logic [drs_pkg::CNT_W-1:0] SLAVE_CYC = drs_pkg::CNT_W'(drs_pkg::SLAVE_CYC),
	parameter logic [drs_pkg::CNT_W-1:0] PASSED_DIAG_LINE_N_CYC = drs_pkg::CNT_W'(drs_pkg::PASSED_DIAG_LINE_N_CYC),
	parameter logic [drs_pkg::CNT_W-1:0] IDLE_CYC = drs_pkg::CNT_W'(drs_pkg::IDLE_CYC),
	parameter bit MISS_USE_TABLE = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	// Drive select jumper, high for master
	input wire logic jumperMaster,
	// Passed-diagnostics line
	input wire logic passedDiagLineIn_n,
	output logic passedDiagLineOut_n,
	output logic passedDiagLineOe,
	// Active/present line
	input wire logic activePresentIn_n,
	output logic activePresentOut_n,
	output logic activePresentOe,
	// Host side status
	output logic busyFlag,
	output logic hostIntrq
);
	import drs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Refuse windows the counters cannot serve
	if (DETECT_CYC == '0 || SLAVE_CYC == '0 || PASSED_DIAG_LINE_N_CYC == '0 || IDLE_CYC == '0) begin : gBadCount
		$error("drs_sequencer: timeout counts must be non-zero");
	end

	// Word index of an aligned register address, IDX_NONE when unmapped
	function automatic logic [2:0] decIdx(input logic [31:0] a);
		logic [2:0] idx;
		idx = IDX_NONE;
		case (a)
			OFS_CTRL: idx = IDX_CTRL;
			OFS_STATUS: idx = IDX_STATUS;
			OFS_TASK: idx = IDX_TASK;
			OFS_HEAD: idx = IDX_HEAD;
			default: idx = IDX_NONE;
		endcase
		return idx;
	endfunction

	// Master error code from presence, passed line and own result
	function automatic logic [7:0] masterErr(input logic present, input logic sig,
			input logic pass, input logic [7:0] code, input logic diagFlow);
		logic [7:0] e;
		e = ERR_MISS_OK;
		if (present && sig) begin
			e = pass ? ERR_OK : ERR_SLV_FAIL;
		end else if (diagFlow && present && !MISS_USE_TABLE) begin
			e = pass ? ERR_DIAG_MISS_OK : 8'(ERR_DIAG_MISS_BASE + code);
		end else begin
			e = pass ? ERR_MISS_OK : ERR_MISS_FAIL;
		end
		return e;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	drs_regs_t r_r;
	drs_regs_t r_nxt;

	logic addrPhase;
	logic srstBit;
	logic diagCmd;
	logic hostCmd;
	logic selfPass;
	logic selfDone;
	logic spinReady;
	logic [7:0] selfCode;

	// Bus phase and control fields
	assign addrPhase = hsel && hready && htrans[1];
	assign srstBit = r_r.ctrl[CTRL_SRST];
	assign diagCmd = r_r.ctrl[CTRL_DIAG];
	assign hostCmd = r_r.ctrl[CTRL_CMD];
	assign selfPass = r_r.ctrl[CTRL_PASS];
	assign selfDone = r_r.ctrl[CTRL_DONE];
	assign spinReady = r_r.ctrl[CTRL_SPIN];
	assign selfCode = r_r.ctrl[CTRL_CODE_LO +: 8];

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic fin;
		logic sig;
		logic slvDone;
		logic clrIrq;
		logic setIrq;
		logic hard;
		logic [2:0] aIdx;
		fin = 1'b0;
		sig = 1'b0;
		slvDone = 1'b0;
		setIrq = 1'b0;
		hard = (r_r.flow == FL_HARD);
		aIdx = decIdx(haddr);
		r_nxt = r_r;
		// Pin synchronisers
		r_nxt.jumpSync = {r_r.jumpSync[0], jumperMaster};
		r_nxt.diagSync = {r_r.diagSync[0], passedDiagLineIn_n};
		r_nxt.actSync = {r_r.actSync[0], activePresentIn_n};
		// Command strobes last one cycle
		r_nxt.ctrl[CTRL_DIAG] = 1'b0;
		r_nxt.ctrl[CTRL_CMD] = 1'b0;
		// Bus data phase write, address phase read
		if (r_r.wrPend && r_r.wrIdx == IDX_CTRL) begin
			r_nxt.ctrl = hwdata[CTRL_W-1:0];
		end
		r_nxt.wrPend = addrPhase && hwrite;
		r_nxt.wrIdx = aIdx;
		clrIrq = addrPhase && !hwrite && aIdx == IDX_STATUS;
		if (addrPhase && !hwrite) begin
			case (aIdx)
				IDX_CTRL: r_nxt.rdata = {16'h0000, r_r.ctrl};
				IDX_STATUS: r_nxt.rdata = {2'h0, r_r.actOut_n, r_r.diagOut_n, r_r.irq, r_r.postsBoth,
					r_r.slavePresent, r_r.isMaster, r_r.statusPeer, r_r.errReg, r_r.statusOwn};
				IDX_TASK: r_nxt.rdata = {r_r.cylHi, r_r.cylLo, r_r.secNum, r_r.secCount};
				IDX_HEAD: r_nxt.rdata = {24'h00_0000, r_r.drvHead};
				default: r_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Sequencer
		case (r_r.state)
			ST_JUMP: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				if (r_r.cnt == SYNC_SETTLE) begin
					r_nxt.isMaster = r_r.jumpSync[1];
					r_nxt.cnt = '0;
					if (r_r.jumpSync[1]) begin
						r_nxt.diagOe = 1'b0;
						r_nxt.actOe = 1'b0;
						r_nxt.state = ST_DETECT;
					end else begin
						r_nxt.diagOut_n = 1'b1;
						r_nxt.diagOe = 1'b1;
						r_nxt.postsBoth = 1'b0;
						r_nxt.state = ST_ANN;
					end
				end
			end
			ST_ANN: begin
				r_nxt.actOut_n = 1'b0;
				r_nxt.actOe = 1'b1;
				r_nxt.state = ST_RUN;
			end
			ST_DETECT: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				if (!r_r.actSync[1]) begin
					r_nxt.slavePresent = 1'b1;
					r_nxt.postsBoth = 1'b0;
					r_nxt.actOut_n = 1'b0;
					r_nxt.actOe = 1'b1;
					r_nxt.cnt = '0;
					r_nxt.state = ST_RUN;
				end else if (r_r.cnt >= DETECT_CYC - 1'b1) begin
					r_nxt.cnt = '0;
					r_nxt.state = ST_RUN;
				end
			end
			ST_RUN: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				if (selfDone || r_r.cnt >= SLAVE_CYC - 1'b1) begin
					r_nxt.cnt = '0;
					if (!r_r.isMaster) begin
						slvDone = 1'b1;
					end else if (r_r.slavePresent) begin
						r_nxt.state = ST_PWAIT;
					end else begin
						fin = 1'b1;
					end
				end
			end
			ST_PWAIT: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				if (!r_r.diagSync[1]) begin
					fin = 1'b1;
					sig = 1'b1;
				end else if (r_r.cnt >= PASSED_DIAG_LINE_N_CYC - 1'b1) begin
					fin = 1'b1;
				end
			end
			ST_SRST: begin
				r_nxt.cnt = '0;
				if (!srstBit) begin
					r_nxt.state = ST_RUN;
				end
			end
			ST_SPIN: begin
				if (spinReady) begin
					r_nxt.statusOwn = ST_READY;
					r_nxt.cnt = '0;
					r_nxt.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (hostCmd) begin
					r_nxt.idleDone = 1'b1;
				end else if (!r_r.idleDone) begin
					r_nxt.cnt = r_r.cnt + 1'b1;
					if (r_r.cnt >= IDLE_CYC - 1'b1) begin
						r_nxt.actOut_n = 1'b1;
						r_nxt.idleDone = 1'b1;
					end
				end
			end
			default: begin
				r_nxt.state = ST_JUMP;
			end
		endcase
		// Slave posts its own result
		if (slvDone) begin
			r_nxt.errReg = (selfDone && selfPass) ? ERR_OK : selfCode;
			r_nxt.diagOut_n = !(selfDone && selfPass);
			r_nxt.statusOwn = hard ? ST_CLEAR : ST_READY;
		end
		// Master posts the combined result
		if (fin) begin
			r_nxt.errReg = masterErr(r_r.slavePresent, sig, selfDone && selfPass, selfCode,
				r_r.flow == FL_DIAG);
			r_nxt.statusOwn = hard ? ST_CLEAR : ST_READY;
			if (r_r.postsBoth) begin
				r_nxt.statusPeer = ST_CLEAR;
			end
			setIrq = (r_r.flow == FL_DIAG);
		end
		// Load task file and move on
		if (slvDone || fin) begin
			r_nxt.secCount = TF_SEC_INIT;
			r_nxt.secNum = TF_SEC_INIT;
			r_nxt.cylLo = TF_ZERO;
			r_nxt.cylHi = TF_ZERO;
			r_nxt.drvHead = TF_ZERO;
			r_nxt.idleDone = 1'b0;
			r_nxt.cnt = '0;
			r_nxt.state = hard ? ST_SPIN : ST_IDLE;
		end
		// Software reset and diagnostic command entry
		if (srstBit && r_r.state != ST_SRST && r_r.state != ST_JUMP && r_r.state != ST_ANN
				&& r_r.state != ST_DETECT) begin
			r_nxt.flow = FL_SRST;
			r_nxt.statusOwn = ST_BUSY;
			if (!r_r.isMaster) begin
				r_nxt.diagOut_n = 1'b1;
			end
			r_nxt.actOut_n = 1'b0;
			r_nxt.actOe = 1'b1;
			r_nxt.cnt = '0;
			r_nxt.state = ST_SRST;
		end else if (diagCmd && (r_r.state == ST_IDLE || r_r.state == ST_SPIN)) begin
			r_nxt.flow = FL_DIAG;
			r_nxt.statusOwn = ST_BUSY;
			if (!r_r.isMaster) begin
				r_nxt.diagOut_n = 1'b1;
			end
			r_nxt.actOut_n = 1'b0;
			r_nxt.actOe = 1'b1;
			r_nxt.cnt = '0;
			r_nxt.state = ST_RUN;
		end
		// Interrupt: a new request wins over a status read
		r_nxt.irq = (r_r.irq && !clrIrq) || setIrq;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r_r <= '0;
			r_r.state <= ST_JUMP;
			r_r.flow <= FL_HARD;
			r_r.postsBoth <= 1'b1;
			r_r.statusOwn <= ST_BUSY;
			r_r.statusPeer <= ST_BUSY;
			r_r.diagOut_n <= 1'b1;
			r_r.actOut_n <= 1'b1;
			r_r.jumpSync <= 2'b11;
			r_r.diagSync <= 2'b11;
			r_r.actSync <= 2'b11;
			r_r.wrIdx <= IDX_NONE;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hrdata = r_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign passedDiagLineOut_n = r_r.diagOut_n;
	assign passedDiagLineOe = r_r.diagOe;
	assign activePresentOut_n = r_r.actOut_n;
	assign activePresentOe = r_r.actOe;
	assign busyFlag = r_r.statusOwn[7];
	assign hostIntrq = r_r.irq;
endmodule
`default_nettype wire

//--- sim/drs_sequencer_sva.sv
// Concurrent checks on the sequencer pins
`default_nettype none
module drs_sequencer_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pins watched
	input wire logic jumperMaster,
	input wire logic passedDiagLineOut_n,
	input wire logic passedDiagLineOe,
	input wire logic activePresentOut_n,
	input wire logic activePresentOe,
	input wire logic busyFlag,
	input wire logic hostIntrq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// Slave set up: passed line driven negated, presence asserted
	sequence announced;
		passedDiagLineOe && passedDiagLineOut_n && activePresentOe && !activePresentOut_n;
	endsequence
	// Start of a software reset or diagnostic flow
	sequence flowStart;
		$rose(busyFlag);
	endsequence
	// Pin relations
	chk_busy_after_reset: assert property ($past(rst) |-> busyFlag && !hostIntrq)
		else $error("busy missing after reset");
	chk_slave_announce: assert property ($fell(rst) && !jumperMaster |-> ##[1:6] announced)
		else $error("slave did not announce");
	chk_master_listens: assert property ($fell(rst) && jumperMaster |-> !activePresentOe [*4])
		else $error("master drove presence while listening");
	chk_master_no_drive: assert property (jumperMaster |-> !passedDiagLineOe)
		else $error("master drove passed line");
	chk_busy_negates_passed: assert property (flowStart |-> ##[0:2] passedDiagLineOut_n)
		else $error("passed line not negated at flow start");
	chk_busy_asserts_active: assert property (flowStart |-> ##[0:2] (activePresentOe && !activePresentOut_n))
		else $error("presence not asserted at flow start");
	chk_passed_when_ready: assert property ($fell(passedDiagLineOut_n) |-> !jumperMaster ##[0:2] !busyFlag)
		else $error("passed asserted while busy");
	chk_intr_when_ready: assert property ($rose(hostIntrq) |-> jumperMaster ##[0:1] !busyFlag)
		else $error("interrupt raised while busy");
endmodule
bind drs_sequencer drs_sequencer_chk u_chk (.ref_clk(ref_clk), .rst(rst), .jumperMaster(jumperMaster),
	.passedDiagLineOut_n(passedDiagLineOut_n), .passedDiagLineOe(passedDiagLineOe),
	.activePresentOut_n(activePresentOut_n), .activePresentOe(activePresentOe),
	.busyFlag(busyFlag), .hostIntrq(hostIntrq));
`default_nettype wire

//--- sim/drs_peer_drive.sv
// Behavioural model of the second drive on the cable
`default_nettype none
module drs_peer_drive (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bench control
	input wire logic present,
	input wire logic kick,
	input wire logic pass,
	input wire logic [7:0] delay,
	// Line drivers
	output logic passOut_n,
	output logic passOe,
	output logic actOut_n,
	output logic actOe
);
	logic [7:0] cnt_r;
	// Announce presence, then post the result after the set delay
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			passOut_n <= 1'b1;
			passOe <= 1'b0;
			actOut_n <= 1'b1;
			actOe <= 1'b0;
			cnt_r <= 8'h00;
		end else if (present) begin
			passOe <= 1'b1;
			actOe <= 1'b1;
			actOut_n <= 1'b0;
			if (kick) begin
				passOut_n <= 1'b1;
				cnt_r <= delay;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
				// A failing drive leaves the line negated
				if (cnt_r == 8'h01 && pass) passOut_n <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/drs_sequencer_test.sv
// Testbench of the reset and diagnostic sequencer
`default_nettype none
module drs_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import drs_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic jumperMaster = 1'b1;
	logic present = 1'b1;
	logic kick = 1'b0;
	logic pass = 1'b0;
	logic [7:0] peerDelay = 8'h05;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	wire [31:0] hrdata;
	wire [1:0] hresp;
	wire hreadyout, passedDiagLineOut_n, passedDiagLineOe, activePresentOut_n, activePresentOe;
	wire busyFlag, hostIntrq, pPassOut_n, pPassOe, pActOut_n, pActOe;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] dCtrl [4] = '{32'h0000_001A, 32'h0000_001A, 32'h0000_2312, 32'h0000_2312};
	logic dPass [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [7:0] dErr [4] = '{ERR_OK, ERR_DIAG_MISS_OK, ERR_DIAG_MISS_BASE + 8'h23, ERR_SLV_FAIL};
	// Pulled-up lines: low when any enabled party drives low
	wire passLine_n = !((passedDiagLineOe && !passedDiagLineOut_n) || (pPassOe && !pPassOut_n));
	wire actLine_n = !((activePresentOe && !activePresentOut_n) || (pActOe && !pActOut_n));
	////////////////////////////////////////
	drs_sequencer #(.DETECT_CYC(34'd20), .SLAVE_CYC(34'd40), .PASSED_DIAG_LINE_N_CYC(34'd60), .IDLE_CYC(34'd80)) u_drs_sequencer (
		.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .jumperMaster(jumperMaster), .passedDiagLineIn_n(passLine_n),
		.passedDiagLineOut_n(passedDiagLineOut_n), .passedDiagLineOe(passedDiagLineOe),
		.activePresentIn_n(actLine_n), .activePresentOut_n(activePresentOut_n),
		.activePresentOe(activePresentOe), .busyFlag(busyFlag), .hostIntrq(hostIntrq));
	drs_peer_drive u_drs_peer_drive (.ref_clk(ref_clk), .rst(rst), .present(present), .kick(kick),
		.pass(pass), .delay(peerDelay), .passOut_n(pPassOut_n), .passOe(pPassOe), .actOut_n(pActOut_n),
		.actOe(pActOe));
	// Clock and hang guard
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// One single AHB-Lite word transfer, entered just after an edge
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	// Poll a register until the masked value matches or tries run out
	task automatic expect_reg(input string n, input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] e, input int tries);
		logic [31:0] r;
		repeat (tries) begin
			ahb(1'b0, a, 32'h0000_0000, r);
			if ((r & m) === e) break;
		end
		chk(n, e, r & m);
	endtask
	task automatic do_reset(input logic master, input logic peer);
		rst <= 1'b1;
		jumperMaster <= master;
		present <= peer;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic peer_start(input logic p);
		pass <= p;
		kick <= 1'b1;
		@(posedge ref_clk);
		kick <= 1'b0;
	endtask
	////////////////////////////////////////
	initial begin
		// Master with a slave on the cable
		do_reset(1'b1, 1'b1);
		expect_reg("status at reset", OFS_STATUS, 32'h00FF_00FF, {8'h00, ST_BUSY, 8'h00, ST_BUSY}, 1);
		expect_reg("slave detected", OFS_STATUS, 32'h0700_0000, 32'h0300_0000, 40);
		peer_start(1'b1);
		wr(OFS_CTRL, 32'h0000_0018);
		expect_reg("reset code", OFS_STATUS, 32'h0000_FF00, {16'h0000, ERR_OK, 8'h00}, 100);
		expect_reg("task file", OFS_TASK, 32'hFFFF_FFFF, {TF_ZERO, TF_ZERO, TF_SEC_INIT, TF_SEC_INIT}, 1);
		expect_reg("drive head", OFS_HEAD, 32'h0000_00FF, {24'h00_0000, TF_ZERO}, 1);
		wr(OFS_CTRL, 32'h0000_0038);
		expect_reg("master ready", OFS_STATUS, 32'h0000_00FF, {24'h00_0000, ST_READY}, 20);
		// Diagnostic command: slave passes, slave silent, self failure, self failure with slave passing
		for (int i = 0; i < 4; i++) begin
			peerDelay <= 8'(i + 2);
			peer_start(dPass[i]);
			wr(OFS_CTRL, dCtrl[i]);
			for (int n = 0; n < 300 && hostIntrq !== 1'b1; n++) @(posedge ref_clk);
			chk("diag interrupt", 32'h0000_0001, hostIntrq);
			expect_reg("diag code", OFS_STATUS, 32'h0000_FFFF, {16'h0000, dErr[i], ST_READY}, 1);
			@(posedge ref_clk);
			chk("interrupt cleared", 32'h0000_0000, hostIntrq);
		end
		// A host command in idle keeps the presence line asserted
		wr(OFS_CTRL, 32'h0000_0004);
		repeat (100) @(posedge ref_clk);
		chk("presence kept", 32'h0000_0000, activePresentOut_n);
		// Slave alone, hardware then software reset
		do_reset(1'b0, 1'b0);
		wr(OFS_CTRL, 32'h0000_0018);
		expect_reg("slave reset", OFS_STATUS, 32'h0100_FFFF, {16'h0000, ERR_OK, ST_CLEAR}, 60);
		chk("passed asserted", 32'h0000_0000, passedDiagLineOut_n);
		wr(OFS_CTRL, 32'h0000_0039);
		repeat (4) @(posedge ref_clk);
		chk("srst busy", 32'h0000_0001, busyFlag);
		chk("srst passed off", 32'h0000_0001, passedDiagLineOut_n);
		wr(OFS_CTRL, 32'h0000_0038);
		expect_reg("srst result", OFS_STATUS, 32'h0000_FFFF, {16'h0000, ERR_OK, ST_READY}, 60);
		chk("passed again", 32'h0000_0000, passedDiagLineOut_n);
		repeat (100) @(posedge ref_clk);
		chk("presence released", 32'h0000_0001, activePresentOut_n);
		// Slave failing its hardware reset posts its code and keeps the passed line negated
		do_reset(1'b0, 1'b0);
		wr(OFS_CTRL, 32'h0000_4210);
		expect_reg("slave fail code", OFS_STATUS, 32'h0000_FFFF, {16'h0000, 8'h42, ST_CLEAR}, 60);
		chk("passed held off", 32'h0000_0001, passedDiagLineOut_n);
		end_of_test();
	end
endmodule
`default_nettype wire
